// file: logic/dfss_device.sv
module dfss_device #(
	parameter int          BIT_DIV   = dfss_pkg::BIT_DIV,
	parameter logic [13:0] SYNC_WORD = dfss_pkg::SYNC_WORD
) (
	input  wire logic clk_sys,
	input  wire logic rst,
	dfss_link_if.dev  link,
	input  wire logic variableRate,  // Mode select
	input  wire logic lineIn,        // Serial bit from far transceiver
	output logic      lineOut,       // Serial bit toward far transceiver
	output logic      lineBitEn,     // One cycle per line bit
	output logic      linkUp,        // Link active
	output logic      rxStuffed,     // Last frame was stuffed
	output logic      txSymbolFrame  // Long frame in line symbols
);
	localparam int FB = dfss_pkg::FSW_BITS;
	localparam int CW = dfss_pkg::CNT_W;
	localparam logic [CW-1:0] FRAME_LEN = CW'(dfss_pkg::FRAME_BITS);
	localparam logic [CW-1:0] STUF_LEN  = CW'(dfss_pkg::STUFFED_BITS);

	// Bit clock divider; rising edge is the bit enable
	logic [7:0] divCnt_ff;
	logic       bitClk_ff;
	wire        divWrap = (divCnt_ff == 8'(BIT_DIV / 2 - 1));
	wire        riseEn  = divWrap && !bitClk_ff;
	wire        fallEn  = divWrap && bitClk_ff;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			divCnt_ff <= 8'h00;
			bitClk_ff <= 1'b0;
		end else begin
			divCnt_ff <= divWrap ? 8'h00 : divCnt_ff + 8'h01;
			if (divWrap) begin
				bitClk_ff <= !bitClk_ff;
			end
		end
	end
	assign link.payloadBitClock = bitClk_ff;
	assign lineBitEn = riseEn;

	// Transmit: count sync word bits after frame pulse rising edge
	logic       tfpPrev_ff;
	logic [4:0] txFsw_ff;   // Remaining sync bits
	logic       txOut_ff;
	wire        tfpRise = link.txFramePulse && !tfpPrev_ff;
	wire        txInFsw = (txFsw_ff != 5'h00);
	wire [3:0]  txIdx   = 4'(txFsw_ff - 5'h01);
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tfpPrev_ff <= 1'b0;
			txFsw_ff   <= 5'h00;
			txOut_ff   <= 1'b0;
		end else if (riseEn) begin
			// Pulse and data sampled at rising bit clock
			tfpPrev_ff <= link.txFramePulse;
			if (tfpRise) begin
				txFsw_ff <= 5'(FB - 1);
				txOut_ff <= SYNC_WORD[FB-1];
			end else if (txInFsw) begin
				// Application data ignored meanwhile
				txFsw_ff <= txFsw_ff - 5'h01;
				txOut_ff <= SYNC_WORD[txIdx];
			end else begin
				txOut_ff <= link.txData;
			end
		end
	end
	assign lineOut = txOut_ff;

	// Receive: shift register and bit counter since last word
	logic [FB-1:0] rxSh_ff;
	logic [CW-1:0] rxCnt_ff;
	logic          locked_ff;
	logic [1:0]    miss_ff;
	logic          rxD_ff;
	logic          rxSt_ff;
	logic          rfp_ff;
	logic          stuf_ff;
	logic          symLong_ff;
	logic [FB-1:0] shNext;
	assign shNext = {rxSh_ff[FB-2:0], lineIn};
	wire  match    = (shNext == SYNC_WORD);
	wire  atShort  = (rxCnt_ff == FRAME_LEN - CW'(1));
	wire  atLong   = (rxCnt_ff == STUF_LEN - CW'(1));
	wire  expected = atShort || (variableRate && atLong);
	wire  overdue  = (rxCnt_ff >= STUF_LEN - CW'(1));
	// Delayed stream: output lags the line by the word length
	wire  outBit   = rxSh_ff[FB-1];
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rxSh_ff    <= '0;
			rxCnt_ff   <= '0;
			locked_ff  <= 1'b0;
			miss_ff    <= 2'h0;
		end else if (riseEn) begin
			rxSh_ff <= shNext;
			if (match && (!locked_ff || expected)) begin
				// Word seen in place, or anywhere while unlocked; restart frame
				rxCnt_ff  <= '0;
				locked_ff <= 1'b1;
				miss_ff   <= 2'h0;
			end else if (overdue) begin
				rxCnt_ff <= '0;
				if (miss_ff == 2'(dfss_pkg::LOSS_FRAMES - 1)) begin
					locked_ff <= 1'b0;
				end else begin
					miss_ff <= miss_ff + 2'h1;
				end
			end else begin
				rxCnt_ff <= rxCnt_ff + CW'(1);
			end
		end
	end

	// Receive outputs except linkUp change on falling edge, valid at rise
	wire frameMark = match && locked_ff && expected;
	// Late word means the frame just ended was stuffed
	wire lateMark  = frameMark && atLong && !atShort;
	logic markDly_ff;
	logic stufDly_ff;  // Held with the mark until the fall
	// Capture at the rise, since counter restarts there
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			markDly_ff <= 1'b0;
			stufDly_ff <= 1'b0;
		end else if (riseEn) begin
			markDly_ff <= frameMark;
			stufDly_ff <= lateMark;
		end
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rxD_ff     <= 1'b0;
			rxSt_ff    <= 1'b0;
			rfp_ff     <= 1'b0;
			stuf_ff    <= 1'b0;
			symLong_ff <= 1'b0;
		end else if (fallEn) begin
			rxD_ff <= outBit;
			// Strobe low over word, and over stuffed bits before it
			rxSt_ff <= locked_ff && (rxCnt_ff >= CW'(FB))
				&& (rxCnt_ff < CW'(FB + dfss_pkg::PAYLOAD_BITS));
			rfp_ff <= markDly_ff;
			// Frame kind updates together with the frame pulse
			if (markDly_ff) begin
				stuf_ff    <= stufDly_ff;
				symLong_ff <= stufDly_ff;
			end
		end
	end
	assign link.rxData          = rxD_ff;
	assign link.rxPayloadStrobe = rxSt_ff;
	assign link.rxFramePulse    = rfp_ff;
	assign linkUp               = locked_ff;
	assign rxStuffed            = stuf_ff;
	assign txSymbolFrame        = symLong_ff;
endmodule

// file: logic/dfss_pkg.sv
package dfss_pkg;
	// Frame geometry
	localparam int FSW_BITS      = 14;    // Sync word length
	localparam int PAYLOAD_BITS  = 4688;  // Payload bits per frame
	localparam int FRAME_BITS    = 4702;  // Unstuffed frame length
	localparam int STUFF_BITS    = 4;     // Extra bits in a stuffed frame
	localparam int STUFFED_BITS  = 4706;  // Stuffed frame length
	localparam int SYM_SHORT     = 2351;  // Line symbols, plain frame
	localparam int SYM_LONG      = 2353;  // Line symbols, stuffed frame
	localparam int CNT_W         = 13;    // Bit counter width
	// Default sync word pattern
	localparam logic [13:0] SYNC_WORD = 14'h0cf3;
	// Link activation: frames missed before the link drops
	localparam int LOSS_FRAMES   = 3;
	// Bit clock divider of the device: 50 MHz / 8
	localparam int BIT_DIV       = 8;
endpackage

// file: logic/dfss_link_if.sv
interface dfss_link_if;
	logic payloadBitClock;   // Bit clock from device
	logic txFramePulse;      // Frame pulse from application
	logic txData;            // Transmit payload
	logic rxData;            // Receive payload
	logic rxPayloadStrobe;   // High while rxData holds payload
	logic rxFramePulse;      // One bit period per received frame
	modport dev (
		output payloadBitClock,
		input  txFramePulse,
		input  txData,
		output rxData,
		output rxPayloadStrobe,
		output rxFramePulse
	);
	modport app (
		input  payloadBitClock,
		output txFramePulse,
		output txData,
		input  rxData,
		input  rxPayloadStrobe,
		input  rxFramePulse
	);
endinterface

// file: logic/dfss_app.sv
// Application framer: frame counter, stuffing, payload source
module dfss_app (
	input  wire logic clk_sys,
	input  wire logic rst,
	dfss_link_if.app  link,
	input  wire logic stuffReq,   // Stuff next frame
	input  wire logic txBit,      // Payload bit to send
	output logic      txTake,     // Pulse: txBit consumed
	output logic      rxBit,      // Received payload bit
	output logic      rxValid,    // Pulse: rxBit valid
	output logic      rxFrame     // Pulse: frame pulse seen
);
	localparam logic [12:0] FLEN = 13'(dfss_pkg::FRAME_BITS);
	localparam logic [12:0] SLEN = 13'(dfss_pkg::STUFFED_BITS);

	// Two-flop sync of link inputs
	logic [1:0] ckS_ff, stS_ff, dS_ff, fS_ff;
	logic       ckPrev_ff;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ckS_ff <= 2'h0;
			stS_ff <= 2'h0;
			dS_ff  <= 2'h0;
			fS_ff  <= 2'h0;
			ckPrev_ff <= 1'b0;
		end else begin
			ckS_ff <= {ckS_ff[0], link.payloadBitClock};
			stS_ff <= {stS_ff[0], link.rxPayloadStrobe};
			dS_ff  <= {dS_ff[0], link.rxData};
			fS_ff  <= {fS_ff[0], link.rxFramePulse};
			ckPrev_ff <= ckS_ff[1];
		end
	end
	wire ckRise = ckS_ff[1] && !ckPrev_ff;
	wire ckFall = !ckS_ff[1] && ckPrev_ff;

	// Frame counter; pulse every 4702, or 4706 when stuffed
	logic [12:0] cnt_ff;
	logic        long_ff;
	logic        tfp_ff, td_ff, take_ff, rb_ff, rv_ff, rf_ff;
	wire         wrap = (cnt_ff == (long_ff ? SLEN : FLEN) - 13'h1);
	// Bit set at count k is sent at the next rise after it,
	// so payload spans counts 13 to 4700
	wire         payload = (cnt_ff >= 13'(dfss_pkg::FSW_BITS - 1))
		&& (cnt_ff < 13'(dfss_pkg::FRAME_BITS - 1));
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			// Start at wrap so the first frame opens with a pulse
			cnt_ff  <= FLEN - 13'h0001;
			long_ff <= 1'b0;
			tfp_ff  <= 1'b0;
			td_ff   <= 1'b0;
			take_ff <= 1'b0;
		end else begin
			take_ff <= 1'b0;
			if (ckFall) begin
				cnt_ff <= wrap ? 13'h0000 : cnt_ff + 13'h0001;
				if (wrap) begin
					long_ff <= stuffReq;
				end
				tfp_ff <= wrap;
				td_ff  <= txBit;
				take_ff <= payload;
			end
		end
	end

	// Receive: sample at bit clock rise, valid gated by strobe
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rb_ff <= 1'b0;
			rv_ff <= 1'b0;
			rf_ff <= 1'b0;
		end else begin
			rv_ff <= ckRise && stS_ff[1];
			rf_ff <= ckRise && fS_ff[1];
			if (ckRise) begin
				rb_ff <= dS_ff[1];
			end
		end
	end
	assign link.txFramePulse = tfp_ff;
	assign link.txData       = td_ff;
	assign txTake  = take_ff;
	assign rxBit   = rb_ff;
	assign rxValid = rv_ff;
	assign rxFrame = rf_ff;
endmodule

// file: sim/dfss_link_assertions.sv
module dfss_link_assertions (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic payloadBitClock,
	input wire logic txFramePulse,
	input wire logic txData,
	input wire logic rxData,
	input wire logic rxPayloadStrobe,
	input wire logic rxFramePulse
);
	timeunit 1ns;
	timeprecision 1ns;
	// Spacings in system clocks
	localparam int BD   = dfss_pkg::BIT_DIV;
	localparam int GAP0 = dfss_pkg::FRAME_BITS * BD;
	localparam int GAP1 = dfss_pkg::STUFFED_BITS * BD;
	localparam int RUN  = dfss_pkg::PAYLOAD_BITS * BD;
	localparam int LOW0 = dfss_pkg::FSW_BITS * BD;
	localparam int LOW1 = LOW0 + dfss_pkg::STUFF_BITS * BD;
	logic [15:0] lowRun_ff;   // Clocks with strobe low
	logic [15:0] highRun_ff;  // Clocks with strobe high
	logic [15:0] txGap_ff;    // Clocks since transmit pulse
	logic [15:0] rxGap_ff;    // Clocks since receive pulse
	logic        txPrev_ff;   // Pulse history
	logic        rxPrev_ff;
	logic        txSeen_ff;   // Spacing known only after a pulse
	logic        rxSeen_ff;
	logic        pay_ff;      // First low run is pre-lock, skip it
	wire logic   txRise = txFramePulse && !txPrev_ff;
	wire logic   rxRise = rxFramePulse && !rxPrev_ff;
	// Strobe run lengths
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lowRun_ff  <= 16'h0000;
			highRun_ff <= 16'h0000;
			pay_ff     <= 1'b0;
		end else begin
			lowRun_ff  <= rxPayloadStrobe ? 16'h0000 : lowRun_ff + 16'h0001;
			highRun_ff <= rxPayloadStrobe ? highRun_ff + 16'h0001 : 16'h0000;
			pay_ff     <= pay_ff | rxPayloadStrobe;
		end
	end
	// Frame pulse spacing
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			{txGap_ff, rxGap_ff} <= 32'h0000_0000;
			{txPrev_ff, rxPrev_ff, txSeen_ff, rxSeen_ff} <= 4'h0;
		end else begin
			txGap_ff  <= txRise ? 16'h0001 : txGap_ff + 16'h0001;
			rxGap_ff  <= rxRise ? 16'h0001 : rxGap_ff + 16'h0001;
			txPrev_ff <= txFramePulse;
			rxPrev_ff <= rxFramePulse;
			txSeen_ff <= txSeen_ff | txRise;
			rxSeen_ff <= rxSeen_ff | rxRise;
		end
	end
	default clocking dc @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	sequence s_oneBit;
		rxFramePulse [*8] ##1 !rxFramePulse;
	endsequence
	property p_bitPeriod;
		$rose(payloadBitClock) |-> ##8 $rose(payloadBitClock);
	endproperty
	property p_rxHold;
		$rose(payloadBitClock) |-> $stable(rxData) && $stable(rxPayloadStrobe);
	endproperty
	property p_txHold;
		$rose(payloadBitClock) |-> $stable(txData) && $stable(txFramePulse);
	endproperty
	property p_syncGap;
		$rose(rxPayloadStrobe) && pay_ff |-> lowRun_ff inside {LOW0, LOW1};
	endproperty
	property p_payRun;
		$fell(rxPayloadStrobe) |-> highRun_ff == RUN;
	endproperty
	property p_txGap;
		txRise && txSeen_ff |-> txGap_ff inside {GAP0, GAP1};
	endproperty
	property p_rxGap;
		rxRise && rxSeen_ff |-> rxGap_ff inside {GAP0, GAP1};
	endproperty
	property p_rxPulse;
		$rose(rxFramePulse) |-> s_oneBit;
	endproperty
	a_bitPeriod: assert property (p_bitPeriod)
		else $error("bit clock period wrong");
	a_rxHold: assert property (p_rxHold)
		else $error("receive data moved at rise");
	a_txHold: assert property (p_txHold)
		else $error("transmit data moved at rise");
	a_syncGap: assert property (p_syncGap)
		else $error("blank length wrong");
	a_payRun: assert property (p_payRun)
		else $error("payload run wrong");
	a_txGap: assert property (p_txGap)
		else $error("transmit frame spacing wrong");
	a_rxGap: assert property (p_rxGap)
		else $error("receive frame spacing wrong");
	a_rxPulse: assert property (p_rxPulse)
		else $error("receive pulse width wrong");
endmodule

// file: sim/tb.sv
`define CHK(nm, e, g) begin \
	check_count++; \
	if ((g) !== (e)) begin \
		n_errors++; \
		$display("unexpected %s: expected %0h, seen %0h", nm, e, g); \
	end \
end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys  = 1'b0;   // 50 MHz
	logic rst      = 1'b1;   // Held at start
	logic stuffReq = 1'b1;   // First two frames stuffed
	logic txBit    = 1'b0;   // Payload source
	logic lineLoop;          // Line looped onto itself
	logic linkUp, rxStuffed, txTake, rxBit, rxValid, rxFrame, expBit;
	logic symLong;           // Long frame in line symbols
	int   n_errors    = 0;
	int   check_count = 0;
	int   takeIdx     = 0;   // Bits consumed so far
	int   takes       = 0;   // Takes since transmit pulse
	int   gap         = 0;   // Clocks since receive pulse
	int   rxFrames    = 0;
	int   txPulses    = 0;
	bit   txPrev      = 0;
	bit   fresh       = 0;   // Consumed, load next bit
	bit   sent[$];           // Bits in flight
	dfss_link_if link ();
	dfss_device i_dfss_device (.clk_sys(clk_sys), .rst(rst), .link(link),
		.variableRate(1'b1), .lineIn(lineLoop), .lineOut(lineLoop),
		.lineBitEn(), .linkUp(linkUp), .rxStuffed(rxStuffed),
		.txSymbolFrame(symLong));
	dfss_app i_dfss_app (.clk_sys(clk_sys), .rst(rst), .link(link),
		.stuffReq(stuffReq), .txBit(txBit), .txTake(txTake), .rxBit(rxBit),
		.rxValid(rxValid), .rxFrame(rxFrame));
	dfss_link_assertions i_dfss_link_assertions (.clk_sys(clk_sys),
		.rst(rst), .payloadBitClock(link.payloadBitClock),
		.txFramePulse(link.txFramePulse), .txData(link.txData),
		.rxData(link.rxData), .rxPayloadStrobe(link.rxPayloadStrobe),
		.rxFramePulse(link.rxFramePulse));
	always #10 clk_sys = ~clk_sys;
	// Corners first: fake sync words in payload, then a run of ones
	function automatic logic nextBit(int i);
		if (i < 196)
			return dfss_pkg::SYNC_WORD[13 - i % 14];
		if (i < 300)
			return 1'b1;
		return 1'($urandom);
	endfunction
	function automatic int frameClocks(logic stuffed);
		return (dfss_pkg::FRAME_BITS + (stuffed ? 4 : 0)) * dfss_pkg::BIT_DIV;
	endfunction
	// Score consumed against returned bits
	always @(posedge clk_sys) begin
		gap++;
		if (txTake) begin
			sent.push_back(txBit);
			takes++;
			fresh = 1;
		end
		if (rxValid && sent.size() > 0) begin
			expBit = sent.pop_front();
			`CHK("payload", expBit, rxBit)
		end
		if (link.txFramePulse && !txPrev) begin
			if (txPulses > 0)
				`CHK("takes", dfss_pkg::PAYLOAD_BITS, takes)
			txPulses++;
			takes = 0;
		end
		txPrev = link.txFramePulse;
		if (rxFrame) begin
			if (rxFrames > 0) begin
				`CHK("stuffed", gap == frameClocks(1'b1), rxStuffed)
				`CHK("long frame", gap == frameClocks(1'b1), symLong)
			end
			$display("receive frame %0d done", rxFrames);
			rxFrames++;
			gap = 0;
		end
	end
	// Bit held across the take, moved at the fall after it
	always @(negedge clk_sys) begin
		if (fresh && !txTake) begin
			takeIdx++;
			txBit <= nextBit(takeIdx);
			fresh = 0;
		end
		if (rxFrames > 0)
			stuffReq <= 1'b0;
	end
	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h26b0));
		txBit = nextBit(0);
		repeat (5) @(posedge clk_sys);
		@(negedge clk_sys) rst = 1'b0;
		repeat (90000) begin
			@(negedge clk_sys);
			if (rxFrames >= 2)
				break;
		end
		`CHK("frames seen", 1'b1, rxFrames >= 2)
		`CHK("link up", 1'b1, linkUp)
		`CHK("in flight", 1'b1, sent.size() < 64)
		report_and_stop();
	end
	// Two frames need about 76000 clocks
	initial begin
		repeat (100000) @(posedge clk_sys);
		n_errors++;
		report_and_stop();
	end
endmodule
